// file: rtl/trig_compare.sv
`default_nettype none
module trig_compare (
   trig_if.cmp tif,              // levels in, flags out
   input wire logic [7:0] rx_count, // receive fifo fill
   input wire logic [7:0] tx_count  // transmit fifo fill
);
   assign tif.rx_ready = (rx_count >= tif.rx_level);
   assign tif.tx_below = (tx_count < tif.tx_level);
endmodule : trig_compare
`default_nettype wire

// file: rtl/trig_if.sv
`default_nettype none
interface trig_if;
   logic [7:0] rx_level;
   logic [7:0] tx_level;
   logic rx_ready;
   logic tx_below;
   modport src (output rx_level, output tx_level, input rx_ready, input tx_below);
   modport cmp (input rx_level, input tx_level, output rx_ready, output tx_below);
endinterface : trig_if
`default_nettype wire

// file: rtl/uart_fic_pkg.sv
// Notes on behaviour
// - rx trigger from control bits 7:6
// - receive ready when count reaches trigger
// - tx trigger from control bits 5:4
// - transmit empty when count below trigger
// - bit 2 flushes transmit fifo, self-clears
// - bit 1 flushes receive fifo, self-clears
// - bit 0 enables both fifos, default off
// - any nonzero level or flow register overrides control codes
// - six priority levels, highest code read
// - one pending interrupt shown until serviced
// - line status: level 1, code 000110
// - receive: level 2, 000100 or 001100
// - tx empty 000010, modem 000000
// - xoff 010000, handshake change 100000
// - status bits 7:6 ones when fifos on
// - bits 5:4 only with enhanced enable
// - xoff flag holds until xon received
// - status bit 0 low while pending
// - receive ready withdrawn below trigger
// - tx empty cleared by status read or write
// - sources gated by enable bits
`default_nettype none
package uart_fic_pkg;
   localparam int CNT_W = 8;
   localparam logic [7:0] FCR_RESET = 8'h00;
   localparam logic [7:0] ISR_RESET = 8'h01;
   localparam int RXT_POS = 6;
   localparam int TXT_POS = 4;
   localparam int TXRST_POS = 2;
   localparam int RXRST_POS = 1;
   localparam int FEN_POS = 0;
   localparam int EFR_EN_POS = 4;
   localparam int IE_RX = 0;
   localparam int IE_TX = 1;
   localparam int IE_LS = 2;
   localparam int IE_MS = 3;
   localparam int IE_XOFF = 5;
   localparam int IE_RTS = 6;
   localparam int IE_CTS = 7;
   localparam logic [5:0] CODE_LS = 6'h06;
   localparam logic [5:0] CODE_RX = 6'h04;
   localparam logic [5:0] CODE_TO = 6'h0C;
   localparam logic [5:0] CODE_TX = 6'h02;
   localparam logic [5:0] CODE_MS = 6'h00;
   localparam logic [5:0] CODE_XOFF = 6'h10;
   localparam logic [5:0] CODE_HS = 6'h20;
   localparam logic [7:0] RXT_L0 = 8'h08;
   localparam logic [7:0] RXT_L1 = 8'h10;
   localparam logic [7:0] RXT_L2 = 8'h18;
   localparam logic [7:0] RXT_L3 = 8'h1C;
   localparam logic [7:0] TXT_L0 = 8'h10;
   localparam logic [7:0] TXT_L1 = 8'h08;
   localparam logic [7:0] TXT_L2 = 8'h18;
   localparam logic [7:0] TXT_L3 = 8'h1E;
endpackage : uart_fic_pkg
`default_nettype wire

// file: rtl/uart_fifo_ctrl_int_status.sv
`default_nettype none
module uart_fifo_ctrl_int_status (
   input wire logic ref_clk,          // 50 MHz clock
   input wire logic arst_n,           // async reset, active low
   input wire logic ctrl_wr,          // write strobe, control register
   input wire logic [7:0] ctrl_wdata, // write data, control register
   output logic [7:0] ctrl_rdata,     // control register readback
   input wire logic status_rd,        // read strobe, status register
   output logic [7:0] status_rdata,   // status value, live
   input wire logic thr_wr,           // host wrote a character to holding reg
   input wire logic [7:0] interrupt_enable,        // enable register
   input wire logic [7:0] enhanced_feature_control,// enhanced features
   input wire logic [7:0] receive_level_threshold, // rx level register
   input wire logic [7:0] transmit_level_threshold,// tx level register
   input wire logic [7:0] flow_threshold_low,      // flow low register
   input wire logic [7:0] flow_threshold_high,     // flow high register
   input wire logic [7:0] rx_count,   // receive fifo fill
   input wire logic [7:0] tx_count,   // transmit fifo fill
   input wire logic line_status_event,// receive error present
   input wire logic rx_timeout,       // receive data timeout
   input wire logic modem_status_event,// modem status change
   input wire logic xoff_detect,      // matching xoff seen, pulse
   input wire logic xon_detect,       // matching xon seen, pulse
   input wire logic special_detect,   // special char seen, pulse
   input wire logic hs_change,        // cts or rts change, pulse
   input wire logic hs_clear,         // handshake change serviced
   output logic fifo_enable,          // fifos enabled
   output logic tx_fifo_flush,        // one-cycle transmit flush
   output logic rx_fifo_flush,        // one-cycle receive flush
   output logic receive_ready_event,  // rx trigger reached, for flow control
   output logic transmit_empty_event, // tx below trigger, for flow control
   output logic irq_pending           // any enabled interrupt pending
);
   typedef struct packed {
      logic [7:0] fifo_control;
      logic tx_flush;
      logic rx_flush;
      logic tx_empty_int;
      logic tx_below_q;
      logic xoff_flag;
      logic hs_flag;
   } state_t;

   state_t st;
   state_t next_st;
   trig_if tif ();
   logic override;
   logic [5:0] code;
   logic pend;
   logic efr_en;

   function automatic logic [7:0] rx_trig(input logic [1:0] sel);
      case (sel)
         2'h0: rx_trig = uart_fic_pkg::RXT_L0;
         2'h1: rx_trig = uart_fic_pkg::RXT_L1;
         2'h2: rx_trig = uart_fic_pkg::RXT_L2;
         default: rx_trig = uart_fic_pkg::RXT_L3;
      endcase
   endfunction : rx_trig

   function automatic logic [7:0] tx_trig(input logic [1:0] sel);
      case (sel)
         2'h0: tx_trig = uart_fic_pkg::TXT_L0;
         2'h1: tx_trig = uart_fic_pkg::TXT_L1;
         2'h2: tx_trig = uart_fic_pkg::TXT_L2;
         default: tx_trig = uart_fic_pkg::TXT_L3;
      endcase
   endfunction : tx_trig

   assign override = |{receive_level_threshold, transmit_level_threshold,
                       flow_threshold_low, flow_threshold_high};
   assign tif.rx_level = override ? receive_level_threshold
                                  : rx_trig(st.fifo_control[uart_fic_pkg::RXT_POS +: 2]);
   assign tif.tx_level = override ? transmit_level_threshold
                                  : tx_trig(st.fifo_control[uart_fic_pkg::TXT_POS +: 2]);

   trig_compare u_cmp (
      .tif(tif),
      .rx_count(rx_count),
      .tx_count(tx_count)
   );

   assign efr_en = enhanced_feature_control[uart_fic_pkg::EFR_EN_POS];

   always_comb begin
      next_st = st;
      next_st.tx_flush = 1'b0;
      next_st.rx_flush = 1'b0;
      next_st.tx_below_q = tif.tx_below;
      if (status_rd || thr_wr) begin
         next_st.tx_empty_int = 1'b0;
      end
      // rising into below-trigger sets; set wins over clear
      if (tif.tx_below && !st.tx_below_q) begin
         next_st.tx_empty_int = 1'b1;
      end
      if (ctrl_wr) begin
         next_st.fifo_control = ctrl_wdata;
         next_st.fifo_control[uart_fic_pkg::TXRST_POS] = 1'b0;
         next_st.fifo_control[uart_fic_pkg::RXRST_POS] = 1'b0;
         next_st.fifo_control[3] = 1'b0;
         next_st.tx_flush = ctrl_wdata[uart_fic_pkg::TXRST_POS];
         next_st.rx_flush = ctrl_wdata[uart_fic_pkg::RXRST_POS];
      end
      if (xon_detect) begin
         next_st.xoff_flag = 1'b0;
      end
      if (xoff_detect || special_detect) begin
         next_st.xoff_flag = 1'b1;
      end
      if (hs_clear || status_rd) begin
         next_st.hs_flag = 1'b0;
      end
      if (hs_change) begin
         next_st.hs_flag = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      pend = 1'b1;
      if (interrupt_enable[uart_fic_pkg::IE_LS] && line_status_event) begin
         code = uart_fic_pkg::CODE_LS;
      end else if (interrupt_enable[uart_fic_pkg::IE_RX] && rx_timeout) begin
         code = uart_fic_pkg::CODE_TO;
      end else if (interrupt_enable[uart_fic_pkg::IE_RX] && tif.rx_ready) begin
         code = uart_fic_pkg::CODE_RX;
      end else if (interrupt_enable[uart_fic_pkg::IE_TX] && st.tx_empty_int) begin
         code = uart_fic_pkg::CODE_TX;
      end else if (interrupt_enable[uart_fic_pkg::IE_MS] && modem_status_event) begin
         code = uart_fic_pkg::CODE_MS;
      end else if (efr_en && interrupt_enable[uart_fic_pkg::IE_XOFF] && st.xoff_flag) begin
         code = uart_fic_pkg::CODE_XOFF;
      end else if (efr_en && (interrupt_enable[uart_fic_pkg::IE_RTS]
                              || interrupt_enable[uart_fic_pkg::IE_CTS]) && st.hs_flag) begin
         code = uart_fic_pkg::CODE_HS;
      end else begin
         code = 6'h00;
         pend = 1'b0;
      end
   end

   // only the top source is shown; fifo bits; bit 0 inverted
   assign status_rdata = {{2{st.fifo_control[uart_fic_pkg::FEN_POS]}}, code[5:1], ~pend};
   assign ctrl_rdata = st.fifo_control;
   assign fifo_enable = st.fifo_control[uart_fic_pkg::FEN_POS];
   assign tx_fifo_flush = st.tx_flush;
   assign rx_fifo_flush = st.rx_flush;
   assign receive_ready_event = tif.rx_ready;
   assign transmit_empty_event = tif.tx_below;
   assign irq_pending = pend;


   // helper terms for the checks, one per priority level
   logic lvl1_on;
   logic lvl2_on;
   logic lvl3_on;
   logic lvl4_on;
   logic lvl5_on;
   logic lvl6_on;
   logic lvl_any;
   assign lvl1_on = interrupt_enable[2] && line_status_event;
   assign lvl2_on = interrupt_enable[0] && (rx_timeout || receive_ready_event);
   assign lvl3_on = interrupt_enable[1] && st.tx_empty_int;
   assign lvl4_on = interrupt_enable[3] && modem_status_event;
   assign lvl5_on = efr_en && interrupt_enable[5] && st.xoff_flag;
   assign lvl6_on = efr_en && (interrupt_enable[6] || interrupt_enable[7]) && st.hs_flag;
   assign lvl_any = lvl1_on || lvl2_on || lvl3_on || lvl4_on || lvl5_on || lvl6_on;

   sequence s_tx_flush_req;
      ctrl_wr && ctrl_wdata[uart_fic_pkg::TXRST_POS];
   endsequence
   sequence s_rx_flush_req;
      ctrl_wr && ctrl_wdata[uart_fic_pkg::RXRST_POS];
   endsequence
   sequence s_tx_below_rise;
      tif.tx_below && !st.tx_below_q;
   endsequence
   sequence s_xoff_event;
      xoff_detect || special_detect;
   endsequence

   // a second flush write right behind the first keeps the pulse high
   // flush one cycle
   chk_tx_flush_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
      s_tx_flush_req |=> tx_fifo_flush
      ##1 (!tx_fifo_flush || $past(ctrl_wr && ctrl_wdata[2])))
      else $error("transmit flush not a single pulse");
   chk_rx_flush_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
      s_rx_flush_req |=> rx_fifo_flush
      ##1 (!rx_fifo_flush || $past(ctrl_wr && ctrl_wdata[1])))
      else $error("receive flush not a single pulse");
   chk_tx_flush_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !(ctrl_wr && ctrl_wdata[2]) |=> !tx_fifo_flush)
      else $error("transmit flush without request");
   chk_rx_flush_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !(ctrl_wr && ctrl_wdata[1]) |=> !rx_fifo_flush)
      else $error("receive flush without request");
   chk_reset_bits_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctrl_rdata[2:1] == 2'h0)
      else $error("flush bits read back set");
   chk_enable_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctrl_wr |=> fifo_enable == $past(ctrl_wdata[0]))
      else $error("fifo enable not taken from write");
   chk_status_fifo_bits: assert property (@(posedge ref_clk) disable iff (!arst_n)
      status_rdata[7:6] == {2{fifo_enable}})
      else $error("status bits 7:6 wrong");
   chk_status_bit0: assert property (@(posedge ref_clk) disable iff (!arst_n)
      status_rdata[0] == !irq_pending)
      else $error("status bit 0 wrong");
   chk_line_status_top: assert property (@(posedge ref_clk) disable iff (!arst_n)
      interrupt_enable[2] && line_status_event |-> status_rdata[5:0] == 6'h06)
      else $error("line status code wrong");
   chk_xoff_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
      st.xoff_flag && !xon_detect |=> st.xoff_flag)
      else $error("xoff flag dropped without xon");
   chk_tx_int_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (status_rd || thr_wr) && !(tif.tx_below && !st.tx_below_q) |=> !st.tx_empty_int)
      else $error("tx empty not cleared");
   chk_rx_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
      interrupt_enable[0] && rx_count >= tif.rx_level && !rx_timeout
      && !(interrupt_enable[2] && line_status_event) |-> status_rdata[5:0] == 6'h04)
      else $error("receive ready code wrong");

   chk_fcr_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !ctrl_wr |=> $stable(ctrl_rdata))
      else $error("control register changed without write");
   chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctrl_rdata[3] == 1'b0)
      else $error("reserved control bit read back set");

   chk_rx_trig_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !override && ctrl_rdata[7:6] == 2'h0 |-> tif.rx_level == 8'h08)
      else $error("receive trigger for code 00 wrong");
   chk_rx_trig_high: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !override && ctrl_rdata[7:6] == 2'h3 |-> tif.rx_level == 8'h1C)
      else $error("receive trigger for code 11 wrong");
   chk_tx_trig_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !override && ctrl_rdata[5:4] == 2'h1 |-> tif.tx_level == 8'h08)
      else $error("transmit trigger for code 01 wrong");
   chk_tx_trig_high: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !override && ctrl_rdata[5:4] == 2'h3 |-> tif.tx_level == 8'h1E)
      else $error("transmit trigger for code 11 wrong");
   chk_level_override: assert property (@(posedge ref_clk) disable iff (!arst_n)
      override |-> tif.rx_level == receive_level_threshold
      && tif.tx_level == transmit_level_threshold)
      else $error("level registers not used as triggers");

   chk_rx_ready_reach: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rx_count >= tif.rx_level |-> receive_ready_event)
      else $error("receive ready missing at trigger");
   chk_rx_ready_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
      rx_count < tif.rx_level |-> !receive_ready_event && status_rdata[5:0] != 6'h04)
      else $error("receive ready kept below trigger");
   chk_tx_below_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
      tx_count < tif.tx_level |-> transmit_empty_event)
      else $error("transmit empty missing below trigger");
   chk_tx_int_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
      s_tx_below_rise |=> st.tx_empty_int)
      else $error("transmit empty interrupt not set");

   chk_timeout_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
      interrupt_enable[0] && rx_timeout && !lvl1_on |-> status_rdata[5:0] == 6'h0C)
      else $error("receive timeout code wrong");
   chk_tx_empty_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
      lvl3_on && !lvl1_on && !lvl2_on |-> status_rdata[5:0] == 6'h02)
      else $error("transmit empty code wrong");
   chk_modem_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
      lvl4_on && !lvl1_on && !lvl2_on && !lvl3_on |-> status_rdata[5:0] == 6'h00 && irq_pending)
      else $error("modem status code wrong");
   chk_xoff_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
      lvl5_on && !lvl1_on && !lvl2_on && !lvl3_on && !lvl4_on |-> status_rdata[5:0] == 6'h10)
      else $error("xoff code wrong");
   chk_hs_code: assert property (@(posedge ref_clk) disable iff (!arst_n)
      lvl6_on && !lvl1_on && !lvl2_on && !lvl3_on && !lvl4_on && !lvl5_on
      |-> status_rdata[5:0] == 6'h20)
      else $error("handshake change code wrong");
   chk_enhanced_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !efr_en |-> status_rdata[5:4] == 2'h0)
      else $error("enhanced status bits set while disabled");

   chk_xoff_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
      s_xoff_event |=> st.xoff_flag)
      else $error("xoff flag not set");
   chk_hs_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (hs_clear || status_rd) && !hs_change |=> !st.hs_flag)
      else $error("handshake flag not cleared");
   chk_any_pending: assert property (@(posedge ref_clk) disable iff (!arst_n)
      lvl_any |-> irq_pending)
      else $error("enabled source not pending");
   chk_none_pending: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !lvl_any |-> status_rdata[5:0] == 6'h01)
      else $error("status not idle without sources");
endmodule : uart_fifo_ctrl_int_status
`default_nettype wire

// file: tb/host_model.sv
`default_nettype none
module host_model (
   input wire logic ref_clk,          // register port clock
   output logic ctrl_wr,              // control write strobe
   output logic [7:0] ctrl_wdata,     // control write data
   output logic status_rd,            // status read strobe
   output logic thr_wr,               // holding register write
   input wire logic [7:0] status_rdata // live status
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ctrl_wr = 1'b0;
      ctrl_wdata = 8'h00;
      status_rd = 1'b0;
      thr_wr = 1'b0;
   end
   // released data is inverted so a stale value never looks valid
   task automatic write_ctrl(input logic [7:0] d);
      @(negedge ref_clk);
      ctrl_wr = 1'b1;
      ctrl_wdata = d;
      @(negedge ref_clk);
      ctrl_wr = 1'b0;
      ctrl_wdata = ~d;
   endtask : write_ctrl
   task automatic read_status(output logic [7:0] d);
      @(negedge ref_clk);
      status_rd = 1'b1;
      d = status_rdata;
      @(negedge ref_clk);
      status_rd = 1'b0;
   endtask : read_status
   task automatic write_thr;
      @(negedge ref_clk);
      thr_wr = 1'b1;
      @(negedge ref_clk);
      thr_wr = 1'b0;
   endtask : write_thr
endmodule : host_model
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic ctrl_wr, status_rd, thr_wr, fifo_enable, tx_fifo_flush, rx_fifo_flush, irq_pending;
   logic receive_ready_event, transmit_empty_event;
   logic [7:0] ctrl_wdata, ctrl_rdata, status_rdata, rd;
   logic [7:0] ien = 8'h00, efc = 8'h00, rxl = 8'h00, txl = 8'h00, flo = 8'h00, fhi = 8'h00;
   logic [7:0] rx_count = 8'h00, tx_count = 8'h20;
   logic lse = 1'b0, tmo = 1'b0, mse = 1'b0, xoff = 1'b0, xon = 1'b0, spc = 1'b0;
   logic hsc = 1'b0, hsclr = 1'b0;
   logic [7:0] rxt [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
   logic [7:0] txt [4] = '{8'h10, 8'h08, 8'h18, 8'h1E};
   int num_errors = 0;
   int n_compared = 0;
   initial forever #10 ref_clk = ~ref_clk;
   uart_fifo_ctrl_int_status uut (.ref_clk(ref_clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
      .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .status_rd(status_rd),
      .status_rdata(status_rdata), .thr_wr(thr_wr), .interrupt_enable(ien),
      .enhanced_feature_control(efc), .receive_level_threshold(rxl),
      .transmit_level_threshold(txl), .flow_threshold_low(flo), .flow_threshold_high(fhi),
      .rx_count(rx_count), .tx_count(tx_count), .line_status_event(lse), .rx_timeout(tmo),
      .modem_status_event(mse), .xoff_detect(xoff), .xon_detect(xon), .special_detect(spc),
      .hs_change(hsc), .hs_clear(hsclr), .fifo_enable(fifo_enable),
      .tx_fifo_flush(tx_fifo_flush), .rx_fifo_flush(rx_fifo_flush),
      .receive_ready_event(receive_ready_event), .transmit_empty_event(transmit_empty_event),
      .irq_pending(irq_pending));
   host_model host (.ref_clk(ref_clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
      .status_rd(status_rd), .thr_wr(thr_wr), .status_rdata(status_rdata));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic step;
      @(negedge ref_clk);
   endtask : step
   task automatic pulse(ref logic s);
      s = 1'b1;
      step();
      s = 1'b0;
   endtask : pulse
   task automatic results;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   task automatic t_reset;
      check(ctrl_rdata, 8'h00);
      check({irq_pending, fifo_enable, status_rdata[7:2]}, 8'h00);
      check(status_rdata, 8'h01);
   endtask : t_reset
   // flushes pulse once, reset bits read zero
   task automatic t_fcr;
      host.write_ctrl(8'h0F);
      check({tx_fifo_flush, rx_fifo_flush, ctrl_rdata}, 10'h301);
      step();
      check({tx_fifo_flush, rx_fifo_flush, status_rdata}, 10'h0C1);
      host.write_ctrl(8'h00);
      check({tx_fifo_flush, rx_fifo_flush, fifo_enable, status_rdata}, 11'h001);
   endtask : t_fcr
   task automatic t_levels;
      for (int i = 0; i < 4; i++) begin
         host.write_ctrl({i[1:0], i[1:0], 4'h1});
         check(ctrl_rdata, {i[1:0], i[1:0], 4'h1});
         rx_count = rxt[i] - 8'h01;
         tx_count = txt[i];
         step();
         check({6'h00, receive_ready_event, transmit_empty_event}, 8'h00);
         rx_count = rxt[i];
         tx_count = txt[i] - 8'h01;
         step();
         check({6'h00, receive_ready_event, transmit_empty_event}, 8'h03);
      end
      fhi = 8'h01;
      rxl = 8'h05;
      txl = 8'h03;
      rx_count = 8'h04;
      tx_count = 8'h03;
      step();
      check({6'h00, receive_ready_event, transmit_empty_event}, 8'h00);
      rx_count = 8'h05;
      tx_count = 8'h02;
      step();
      check({6'h00, receive_ready_event, transmit_empty_event}, 8'h03);
      {fhi, rxl, txl, rx_count, tx_count} = {32'h0, 8'h20};
   endtask : t_levels
   // walk down the priority ladder
   task automatic t_prio;
      host.write_ctrl(8'h01);
      {ien, efc, lse, tmo, mse, rx_count, tx_count} = {8'hFF, 8'h10, 3'h7, 8'h08, 8'h00};
      xoff = 1'b1;
      pulse(hsc);
      xoff = 1'b0;
      check({7'h00, irq_pending, status_rdata}, 16'h01C6);
      lse = 1'b0;
      step();
      check(status_rdata, 8'hCC);
      tmo = 1'b0;
      step();
      check(status_rdata, 8'hC4);
      rx_count = 8'h07;
      step();
      check(status_rdata, 8'hC2);
      host.write_thr();
      check(status_rdata, 8'hC0);
      mse = 1'b0;
      step();
      check(status_rdata, 8'hD0);
      pulse(xon);
      check(status_rdata, 8'hE0);
      host.read_status(rd);
      check({rd, status_rdata}, 16'hE0C1);
      pulse(xoff);
      host.read_status(rd);
      check(status_rdata, 8'hD0);
      pulse(xon);
      // the fill must leave the below-trigger range before a new entry counts
      tx_count = 8'h10;
      step();
      tx_count = 8'h00;
      step();
      host.read_status(rd);
      check({rd, status_rdata}, 16'hC2C1);
      pulse(hsc);
      check(status_rdata, 8'hE0);
      pulse(hsclr);
      check(status_rdata, 8'hC1);
      ien = 8'h00;
      lse = 1'b1;
      step();
      check({7'h00, irq_pending, status_rdata}, 16'h00C1);
      {ien, efc, lse} = {8'hFF, 8'h00, 1'b0};
      pulse(xoff);
      check(status_rdata, 8'hC1);
   endtask : t_prio
   initial begin
      #100us;
      num_errors++;
      results();
   end
   initial begin
      repeat (8) @(negedge ref_clk);
      arst_n = 1'b1;
      step();
      t_reset();
      t_fcr();
      t_levels();
      t_prio();
      results();
   end
endmodule : tb
`default_nettype wire
